// ===== pkg/irq_route_pkg.sv
// Constants shared by the PCI interrupt router and its helpers.
// Assumes a single 20 MHz system clock and a synchronous active-high reset.
package irq_route_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int          NUM_ROUTE      = 8;
   localparam int          NUM_PIC_IRQ    = 16;
   localparam int          NUM_APIC_IRQ   = 24;
   localparam int          SEL_W          = 4;
   localparam int          NUM_LEGACY_SRC = 3;

   // ---------------------------------------------------------------
   // Fixed system lines
   // ---------------------------------------------------------------
   localparam logic [4:0]  IRQ_TIMER      = 5'h00;
   localparam logic [4:0]  IRQ_KEYBOARD   = 5'h01;
   localparam logic [4:0]  IRQ_CASCADE    = 5'h02;
   localparam logic [4:0]  IRQ_RTC        = 5'h08;
   localparam logic [4:0]  IRQ_FPU        = 5'h0d;
   localparam logic [4:0]  IRQ_APIC_BASE  = 5'h10;

   // Lines a route input may be steered onto in PIC mode: 3-7, 9-12, 14, 15
   localparam logic [15:0] PIC_ROUTABLE   = 16'hdef8;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [3:0]  RST_SERIAL1    = 4'h4;
   localparam logic [3:0]  RST_SERIAL2    = 4'h3;
   localparam logic [3:0]  RST_PARALLEL1  = 4'h7;
   localparam logic [3:0]  RST_ROUTE_SEL  = 4'h0;

   // Onboard route assignments: network on E, FireWire on D
   localparam int          ROUTE_IDX_D    = 3;
   localparam int          ROUTE_IDX_E    = 4;

   typedef enum logic [1:0] {
      MODE_PIC  = 2'b01,
      MODE_APIC = 2'b10
   } irq_mode_t;

endpackage : irq_route_pkg

// ===== rtl/irq_sync2.sv
// Two-stage synchroniser for a bus of asynchronous levels.
// Assumes the inputs are quasi-static relative to CLK_SYS.
`timescale 1ns/1ns
module irq_sync2 #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;

   // First stage is read only by the second stage.
   // Both stages reset to the idle level of each pin, so that no false request follows reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= rst_val;
         dout   <= rst_val;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : irq_sync2

// ===== rtl/irq_steer.sv
// Steers one route request onto a 16-line PIC vector by its selector.
// Assumes the selector is already checked against the routable set.
`timescale 1ns/1ns
module irq_steer (
   input  wire logic        req,
   input  wire logic [3:0]  sel,
   input  wire logic        ok,
   output logic      [15:0] vec
);
   always_comb begin
      vec = 16'h0000;
      if (req && ok) begin
         vec[sel] = 1'b1;
      end
   end
endmodule : irq_steer

// ===== rtl/pci_interrupt_router.sv
// PCI interrupt router: eight shared route request lines onto system IRQs.
// Assumes open-drain active-low request pins and a configuration agent
// that drives mode and selectors as plain levels on CLK_SYS.
`timescale 1ns/1ns

module pci_interrupt_router (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        APIC_MODE,
   input  wire logic [7:0]  ROUTE_REQUEST_N,
   input  wire logic        NET_INTA_N,
   input  wire logic        FW_INTA_N,
   input  wire logic [31:0] ROUTE_SEL,
   input  wire logic        TIMER_IRQ,
   input  wire logic        KEYBOARD_IRQ,
   input  wire logic        CASCADE_IRQ,
   input  wire logic        RTC_IRQ,
   input  wire logic        FPU_IRQ,
   input  wire logic        SERIAL1_IRQ,
   input  wire logic        SERIAL2_IRQ,
   input  wire logic        PARALLEL1_IRQ,
   input  wire logic        LEGACY_SEL_WE,
   input  wire logic [11:0] LEGACY_SEL,
   output logic      [23:0] SYS_IRQ,
   output logic      [7:0]  ROUTE_ACTIVE,
   output logic      [11:0] LEGACY_SEL_NOW,
   output logic      [1:0]  MODE_NOW
);

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   localparam int NS = 8 + 2 + 8 + 1;
   logic [NS-1:0] raw_in;
   logic [NS-1:0] sync_in;

   assign raw_in = {APIC_MODE, PARALLEL1_IRQ, SERIAL2_IRQ, SERIAL1_IRQ, FPU_IRQ,
                    RTC_IRQ, CASCADE_IRQ, KEYBOARD_IRQ, TIMER_IRQ,
                    FW_INTA_N, NET_INTA_N, ROUTE_REQUEST_N};

   irq_sync2 #(.W(NS)) u_sync (
      .clk     (CLK_SYS),
      .rst     (RST),
      .din     (raw_in),
      .rst_val ({1'b0, 8'h00, 2'b11, 8'hff}),   // Idle levels: low-active pins high
      .dout    (sync_in)
   );

   logic [7:0] req_n_s;
   logic       net_n_s;
   logic       fw_n_s;
   logic [7:0] fixed_s;
   logic       apic_s;
   assign req_n_s = sync_in[7:0];
   assign net_n_s = sync_in[8];
   assign fw_n_s  = sync_in[9];
   assign fixed_s = sync_in[17:10];
   assign apic_s  = sync_in[18];

   // ---------------------------------------------------------------
   // Route request levels
   // ---------------------------------------------------------------
   // Extra guard: nothing is passed on at the edge that leaves reset
   logic       run_q;
   logic [7:0] req_lvl;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         run_q <= 1'b0;
      end else begin
         run_q <= 1'b1;
      end
   end

   // Wired-AND of open-drain sharers: active while any sharer pulls low
   always_comb begin
      req_lvl = ~req_n_s;
      req_lvl[irq_route_pkg::ROUTE_IDX_E] = ~(req_n_s[irq_route_pkg::ROUTE_IDX_E] & net_n_s);
      req_lvl[irq_route_pkg::ROUTE_IDX_D] = ~(req_n_s[irq_route_pkg::ROUTE_IDX_D] & fw_n_s);
      if (!run_q) begin
         req_lvl = 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Mode
   // ---------------------------------------------------------------
   irq_route_pkg::irq_mode_t mode_q;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         mode_q <= irq_route_pkg::MODE_PIC;
      end else if (apic_s) begin
         mode_q <= irq_route_pkg::MODE_APIC;
      end else begin
         mode_q <= irq_route_pkg::MODE_PIC;
      end
   end

   // ---------------------------------------------------------------
   // Selector checking
   // ---------------------------------------------------------------
   // Used for every route and legacy selector, hence a function
   function automatic logic sel_ok(input logic [3:0] s);
      sel_ok = irq_route_pkg::PIC_ROUTABLE[s];
   endfunction : sel_ok

   // ---------------------------------------------------------------
   // PIC steering of route requests
   // ---------------------------------------------------------------
   logic [15:0] steer_vec [8];
   logic [15:0] pic_pci;

   // Selectors are read live each cycle so software may move them any time
   genvar g;
   generate
      for (g = 0; g < irq_route_pkg::NUM_ROUTE; g++) begin : g_steer
         irq_steer u_steer (
            .req (req_lvl[g]),
            .sel (ROUTE_SEL[g*4 +: 4]),
            .ok  (sel_ok(ROUTE_SEL[g*4 +: 4])),
            .vec (steer_vec[g])
         );
      end
   endgenerate

   // OR-merge lets several inputs land on one line
   always_comb begin
      pic_pci = 16'h0000;
      for (int i = 0; i < irq_route_pkg::NUM_ROUTE; i++) begin
         pic_pci = pic_pci | steer_vec[i];
      end
   end

   // ---------------------------------------------------------------
   // Legacy serial and parallel line selectors
   // ---------------------------------------------------------------
   logic [3:0] ser1_sel_q;
   logic [3:0] ser2_sel_q;
   logic [3:0] par1_sel_q;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ser1_sel_q <= irq_route_pkg::RST_SERIAL1;
         ser2_sel_q <= irq_route_pkg::RST_SERIAL2;
         par1_sel_q <= irq_route_pkg::RST_PARALLEL1;
      end else if (LEGACY_SEL_WE) begin
         // Illegal targets are refused so fixed lines stay clean
         if (sel_ok(LEGACY_SEL[3:0])) begin
            ser1_sel_q <= LEGACY_SEL[3:0];
         end
         if (sel_ok(LEGACY_SEL[7:4])) begin
            ser2_sel_q <= LEGACY_SEL[7:4];
         end
         if (sel_ok(LEGACY_SEL[11:8])) begin
            par1_sel_q <= LEGACY_SEL[11:8];
         end
      end
   end

   logic [15:0] legacy_vec;
   always_comb begin
      legacy_vec = 16'h0000;
      if (run_q && fixed_s[5]) begin
         legacy_vec[ser1_sel_q] = 1'b1;
      end
      if (run_q && fixed_s[6]) begin
         legacy_vec[ser2_sel_q] = 1'b1;
      end
      if (run_q && fixed_s[7]) begin
         legacy_vec[par1_sel_q] = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Fixed system lines
   // ---------------------------------------------------------------
   logic [15:0] fixed_vec;
   always_comb begin
      fixed_vec = 16'h0000;
      fixed_vec[irq_route_pkg::IRQ_TIMER[3:0]]    = fixed_s[0];
      fixed_vec[irq_route_pkg::IRQ_KEYBOARD[3:0]] = fixed_s[1];
      fixed_vec[irq_route_pkg::IRQ_CASCADE[3:0]]  = fixed_s[2];
      fixed_vec[irq_route_pkg::IRQ_RTC[3:0]]      = fixed_s[3];
      fixed_vec[irq_route_pkg::IRQ_FPU[3:0]]      = fixed_s[4];
   end

   // ---------------------------------------------------------------
   // Output assembly
   // ---------------------------------------------------------------
   logic [23:0] irq_d;
   always_comb begin
      irq_d = {8'h00, fixed_vec | legacy_vec};
      if (mode_q == irq_route_pkg::MODE_APIC) begin
         irq_d[23:16] = req_lvl;
      end else begin
         irq_d[15:0] = irq_d[15:0] | pic_pci;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         SYS_IRQ <= 24'h000000;
      end else begin
         SYS_IRQ <= irq_d;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ROUTE_ACTIVE   <= 8'h00;
         LEGACY_SEL_NOW <= {irq_route_pkg::RST_PARALLEL1, irq_route_pkg::RST_SERIAL2,
                            irq_route_pkg::RST_SERIAL1};
         MODE_NOW       <= irq_route_pkg::MODE_PIC;
      end else begin
         ROUTE_ACTIVE   <= req_lvl;
         LEGACY_SEL_NOW <= {par1_sel_q, ser2_sel_q, ser1_sel_q};
         MODE_NOW       <= mode_q;
      end
   end

endmodule : pci_interrupt_router

// ===== dv/irq_source_model.sv
// ---------------------------------------------------------------
// PCI interrupt sources: cards and onboard devices, open-drain
// ---------------------------------------------------------------
// Assumes pull-ups on every request line, so a released line reads high.
`timescale 1ns/1ns
module irq_source_model (
   input  wire logic       clk,
   input  wire logic [7:0] card_req,
   input  wire logic       net_req,
   input  wire logic       fw_req,
   output logic      [7:0] req_n = 8'hff,
   output logic            net_n = 1'b1,
   output logic            fw_n  = 1'b1
);
   // Sources stay low until serviced; sharers drive separate pins that the router merges
   always_ff @(posedge clk) begin
      req_n <= ~card_req;
      net_n <= ~net_req;
      fw_n  <= ~fw_req;
   end
endmodule : irq_source_model

// ===== dv/irq_router_chk.sv
// ---------------------------------------------------------------
// Port checker for the PCI interrupt router
// ---------------------------------------------------------------
// Assumes one clock; pin-to-output latency of three edges.
`timescale 1ns/1ns
module irq_router_chk (
   input wire logic        CLK_SYS,
   input wire logic        RST,
   input wire logic        APIC_MODE,
   input wire logic [7:0]  ROUTE_REQUEST_N,
   input wire logic        NET_INTA_N,
   input wire logic        FW_INTA_N,
   input wire logic        TIMER_IRQ,
   input wire logic        KEYBOARD_IRQ,
   input wire logic        CASCADE_IRQ,
   input wire logic        RTC_IRQ,
   input wire logic        FPU_IRQ,
   input wire logic        LEGACY_SEL_WE,
   input wire logic [11:0] LEGACY_SEL,
   input wire logic [23:0] SYS_IRQ,
   input wire logic [7:0]  ROUTE_ACTIVE,
   input wire logic [11:0] LEGACY_SEL_NOW,
   input wire logic [1:0]  MODE_NOW
);
   logic [7:0] act;
   logic [3:0] fix;
   logic [2:0] up_q;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   assign act = ~ROUTE_REQUEST_N | {3'h0, ~NET_INTA_N, ~FW_INTA_N, 3'h0};
   assign fix = {FPU_IRQ, RTC_IRQ, KEYBOARD_IRQ, TIMER_IRQ};
   // Pipeline still holds reset-time samples for a few edges
   always_ff @(posedge CLK_SYS) begin
      if (RST) up_q <= 3'h0;
      else if (up_q != 3'h7) up_q <= up_q + 3'h1;
   end
   sequence s_good_wr;
      LEGACY_SEL_WE && irq_route_pkg::PIC_ROUTABLE[LEGACY_SEL[3:0]] &&
      irq_route_pkg::PIC_ROUTABLE[LEGACY_SEL[7:4]] && irq_route_pkg::PIC_ROUTABLE[LEGACY_SEL[11:8]]
      ##1 !LEGACY_SEL_WE;
   endsequence
   property p_pic_top; !APIC_MODE [*5] |-> SYS_IRQ[23:16] == 8'h00; endproperty
   property p_apic_map; (APIC_MODE && up_q == 3'h7) [*6] |-> SYS_IRQ[23:16] == $past(act, 3); endproperty
   property p_mode; APIC_MODE [*5] |-> MODE_NOW == 2'b10; endproperty
   property p_active; up_q == 3'h7 |-> ROUTE_ACTIVE == $past(act, 3); endproperty
   property p_cascade; up_q == 3'h7 |-> SYS_IRQ[2] == $past(CASCADE_IRQ, 3); endproperty
   property p_fixed; up_q == 3'h7 |-> {SYS_IRQ[13], SYS_IRQ[8], SYS_IRQ[1:0]} == $past(fix, 3); endproperty
   property p_sel_rst; $fell(RST) |-> LEGACY_SEL_NOW == 12'h734; endproperty
   property p_sel_wr; s_good_wr |-> ##1 LEGACY_SEL_NOW == $past(LEGACY_SEL, 2); endproperty
   a_pic_top: assert property (p_pic_top) else $error("upper lines set in PIC mode");
   a_apic_map: assert property (p_apic_map) else $error("APIC line mismatch");
   a_mode: assert property (p_mode) else $error("mode not APIC");
   a_active: assert property (p_active) else $error("route activity mismatch");
   a_cascade: assert property (p_cascade) else $error("cascade line mismatch");
   a_fixed: assert property (p_fixed) else $error("fixed line mismatch");
   a_sel_rst: assert property (p_sel_rst) else $error("legacy default wrong");
   a_sel_wr: assert property (p_sel_wr) else $error("legacy write lost");
endmodule : irq_router_chk
bind pci_interrupt_router irq_router_chk u_chk (.CLK_SYS, .RST, .APIC_MODE, .ROUTE_REQUEST_N, .NET_INTA_N,
   .FW_INTA_N, .TIMER_IRQ, .KEYBOARD_IRQ, .CASCADE_IRQ, .RTC_IRQ, .FPU_IRQ, .LEGACY_SEL_WE, .LEGACY_SEL,
   .SYS_IRQ, .ROUTE_ACTIVE, .LEGACY_SEL_NOW, .MODE_NOW);

// ===== dv/pci_interrupt_router_bench.sv
// ---------------------------------------------------------------
// Self-checking bench for the PCI interrupt router
// ---------------------------------------------------------------
// Assumes the source model adds one edge before the three-edge path.
`timescale 1ns/1ns
module pci_interrupt_router_bench;
   logic        CLK_SYS, RST, APIC_MODE, LEGACY_SEL_WE, net_req, fw_req, NET_INTA_N, FW_INTA_N;
   logic [7:0]  card_req, ROUTE_REQUEST_N, ROUTE_ACTIVE, leg;
   logic [31:0] ROUTE_SEL;
   logic [11:0] LEGACY_SEL, LEGACY_SEL_NOW;
   logic [23:0] SYS_IRQ;
   logic [1:0]  MODE_NOW;
   int          n_errors, checks_done;
   irq_source_model u_src (.clk(CLK_SYS), .card_req, .net_req, .fw_req, .req_n(ROUTE_REQUEST_N),
      .net_n(NET_INTA_N), .fw_n(FW_INTA_N));
   pci_interrupt_router u_dut (.CLK_SYS, .RST, .APIC_MODE, .ROUTE_REQUEST_N, .NET_INTA_N, .FW_INTA_N,
      .ROUTE_SEL, .TIMER_IRQ(leg[0]), .KEYBOARD_IRQ(leg[1]), .CASCADE_IRQ(leg[2]), .RTC_IRQ(leg[3]),
      .FPU_IRQ(leg[4]), .SERIAL1_IRQ(leg[5]), .SERIAL2_IRQ(leg[6]), .PARALLEL1_IRQ(leg[7]),
      .LEGACY_SEL_WE, .LEGACY_SEL, .SYS_IRQ, .ROUTE_ACTIVE, .LEGACY_SEL_NOW, .MODE_NOW);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Sample at the falling edge so register updates have landed
   task automatic settle(input int n);
      repeat (n) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
   endtask : settle
   task automatic t_pic;
      @(posedge CLK_SYS); card_req <= 8'h02;
      for (int t = 0; t < 16; t++) begin
         @(posedge CLK_SYS); ROUTE_SEL[7:4] <= t[3:0];
         settle(5);
         chk(SYS_IRQ, irq_route_pkg::PIC_ROUTABLE[t] ? 32'h1 << t : 32'h0);
      end
      @(posedge CLK_SYS); card_req <= 8'h00;
      $display("test pic targets done");
   endtask : t_pic
   task automatic t_share;
      @(posedge CLK_SYS); ROUTE_SEL <= 32'h000c_6a0a; card_req <= 8'h05;
      settle(5); chk(SYS_IRQ, 32'h400);
      @(posedge CLK_SYS); card_req <= 8'h04;
      settle(5); chk(SYS_IRQ, 32'h400);
      @(posedge CLK_SYS); card_req <= 8'h00; net_req <= 1'b1;
      settle(5); chk({ROUTE_ACTIVE, SYS_IRQ}, 32'h1000_1000);
      @(posedge CLK_SYS); net_req <= 1'b0; fw_req <= 1'b1;
      settle(5); chk({ROUTE_ACTIVE, SYS_IRQ}, 32'h0800_0040);
      @(posedge CLK_SYS); fw_req <= 1'b0;
      $display("test sharing done");
   endtask : t_share
   task automatic t_apic;
      @(posedge CLK_SYS); APIC_MODE <= 1'b1; ROUTE_SEL <= 32'h5555_5555;
      for (int g = 0; g < 8; g++) begin
         @(posedge CLK_SYS); card_req <= 8'h1 << g;
         settle(6);
         chk(SYS_IRQ, 32'h1 << (16 + g));
      end
      chk(MODE_NOW, 2'b10);
      @(posedge CLK_SYS); APIC_MODE <= 1'b0; card_req <= 8'hff;
      settle(6); chk({MODE_NOW, SYS_IRQ}, 32'h0100_0020);
      @(posedge CLK_SYS); card_req <= 8'h00;
      $display("test apic done");
   endtask : t_apic
   task automatic wr(input logic [11:0] v);
      @(posedge CLK_SYS); LEGACY_SEL_WE <= 1'b1; LEGACY_SEL <= v;
      @(posedge CLK_SYS); LEGACY_SEL_WE <= 1'b0;
   endtask : wr
   task automatic t_legacy;
      chk(LEGACY_SEL_NOW, 12'h734);
      @(posedge CLK_SYS); leg <= 8'h20;
      settle(4); chk(SYS_IRQ, 32'h10);
      wr(12'hd3b); // Parallel field 13 must be refused
      settle(3); chk(LEGACY_SEL_NOW, 32'h73b);
      chk(SYS_IRQ, 32'h800);
      wr(12'h734);
      settle(3); chk(LEGACY_SEL_NOW, 12'h734);
      @(posedge CLK_SYS); leg <= 8'h1f;
      settle(4); chk(SYS_IRQ, 32'h2107);
      @(posedge CLK_SYS); leg <= 8'h00;
      $display("test legacy lines done");
   endtask : t_legacy
   task automatic conclude;
      $display("checks %0d, errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   initial begin
      CLK_SYS = 1'b0;
      forever #25 CLK_SYS = ~CLK_SYS;
   end
   initial begin
      RST = 1'b1; APIC_MODE = 1'b0; LEGACY_SEL_WE = 1'b0; LEGACY_SEL = 12'h000; ROUTE_SEL = 32'h0;
      card_req = 8'h00; net_req = 1'b0; fw_req = 1'b0; leg = 8'h00;
      n_errors = 0; checks_done = 0;
      repeat (12) @(posedge CLK_SYS);
      RST <= 1'b0;
      settle(1);
      t_legacy;
      t_pic;
      t_share;
      t_apic;
      conclude;
   end
   // Tests need under 400 cycles; a hang is cut well past that
   initial begin
      #(50 * 4000);
      n_errors++;
      conclude;
   end
endmodule : pci_interrupt_router_bench
